/* File: design/pss_sequencer.sv */
`timescale 1ns/10ps
`include "pss_defs.svh"
// Notes on behaviour
// R1: first fs after enable loads first_set_index
// R2: software keeps first_set_index at zero
// R3: set_pick_index picks set for writes, load
// R4: each set has paths 0/1, own fields
// R5: software gives both paths different sources
// R6: path 1 steps through sets in turn
// R7: path 0 returns to set 0 anytime
// R8: firing source loads that path's successor
// R9: sources: lines 1,3,4, sw 1-3, cnt, fs
// R10: polarity is level-high only
// R11: sync source records, next fs loads
// R12: counter end is synchronous; lines, fs load at once
// R13: software pulse selects and loads at once
// R14: software pulse latency is unspecified
// R15: frame start source loads now, path 1
// R16: line level sampled at fs, high loads
// R17: counter runs 1..limit, end allows advance
// R18: frame_count_limit accepts 1 to 256
// R19: counter end offered on path 1 only
// R20: software avoids pulses in real time use
// R21: 32 stored sets, index 0 to 31
// R22: no config writes while sequencer on
// R23: software links J to J+1, last to 0
// R24: no request keeps the current set
// R25: both paths at once: path 0 wins; a path 1 pulse at an fs overrides a path 0 line
module pss_sequencer #(
  parameter int NSETS = 32
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_start,
  input  wire logic        line1_in,
  input  wire logic        line3_in,
  input  wire logic        line4_in,
  output logic [4:0]       active_set,
  output logic             set_load,
  output logic             seq_running
);

  // ==========================================
  // elaboration checks
  if (NSETS < 1 || NSETS > 32) begin : g_chk
    $error("NSETS must be 1 to 32");
  end

  pss_pkg::pss_state_s q;
  pss_pkg::pss_state_s d;

  // ==========================================
  // helpers
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `PSS_A_CTRL)  || (a == `PSS_A_FIRST) ||
              (a == `PSS_A_PICK)  || (a == `PSS_A_ROUTE) ||
              (a == `PSS_A_NEXT)  || (a == `PSS_A_SRC)   ||
              (a == `PSS_A_LIMIT) || (a == `PSS_A_SWP)   ||
              (a == `PSS_A_STAT)  || (a == `PSS_A_LOAD);
  endfunction : reg_hit

  // whole word compared, so an index of 32 or more cannot alias a low set
  function automatic logic set_ok(input logic [31:0] v);
    set_ok = v < 32'(NSETS);
  endfunction : set_ok

  // line and frame start sources only; counter end is handled through the pending slot
  function automatic logic fires(input pss_pkg::pss_src_e s,
                                 input logic              path1,
                                 input logic [2:0]        lines);
    case (s)
      pss_pkg::SRC_LINE1:  fires = lines[0]; // R16
      pss_pkg::SRC_LINE3:  fires = lines[1]; // R16
      pss_pkg::SRC_LINE4:  fires = lines[2]; // R16
      pss_pkg::SRC_FSTART: fires = path1; // R15
      default:             fires = 1'b0;
    endcase
  endfunction : fires

  logic             acc;
  logic             wr;
  logic             cfg_ok;
  logic             f0;
  logic             f1;
  logic             cnt_end;
  logic             sw0;
  logic             sw1;
  logic [8:0]       cnt_n;
  logic [2:0]       lines;
  pss_pkg::pss_path_s p0;
  pss_pkg::pss_path_s p1;

  // ==========================================
  // next state
  always_comb begin
    d        = q;
    d.load_p = 1'b0;
    acc      = psel & penable & ~q.pready;
    wr       = psel & penable & q.pready & pwrite;
    cfg_ok   = ~q.seq_on & q.cfg_on; // R22
    lines    = {line4_in, line3_in, line1_in};
    p0       = q.tbl[q.active][0]; // R4
    p1       = q.tbl[q.active][1]; // R4
    f0       = fires(p0.src, 1'b0, lines);
    f1       = fires(p1.src, 1'b1, lines);
    cnt_n    = (q.cnt >= q.limit) ? 9'h001 : q.cnt + 9'h001; // R17
    cnt_end  = (cnt_n == q.limit) && (p1.src == pss_pkg::SRC_CNTEND); // R19
    sw0      = 1'b0;
    sw1      = 1'b0;

    // apb answer: one wait state, data and error ride with pready
    d.pready  = acc;
    d.pslverr = 1'b0;
    if (acc) begin
      d.pslverr = ~reg_hit(paddr);
      d.prdata  = 32'h0;
      case (paddr)
        `PSS_A_CTRL:  d.prdata = {30'h0, q.cfg_on, q.seq_on};
        `PSS_A_FIRST: d.prdata = {27'h0, q.first};
        `PSS_A_PICK:  d.prdata = {27'h0, q.pick};
        `PSS_A_ROUTE: d.prdata = {31'h0, q.route};
        `PSS_A_NEXT:  d.prdata = {27'h0, q.tbl[q.pick][q.route].succ};
        `PSS_A_SRC: begin
          d.prdata = {29'h0, q.tbl[q.pick][q.route].src};
          d.prdata[`PSS_B_POL] = 1'b1; // R10
        end
        `PSS_A_LIMIT: d.prdata = {23'h0, q.limit};
        `PSS_A_STAT: begin
          d.prdata[4:0]          = q.active;
          d.prdata[`PSS_B_ARMED] = q.armed;
          d.prdata[`PSS_B_PEND]  = q.pend_v;
          d.prdata[`PSS_B_RUN]   = q.seq_on & ~q.armed;
          d.prdata[`PSS_B_CNT +: 9] = q.cnt;
        end
        default: d.prdata = 32'h0;
      endcase
    end

    // register writes
    if (wr) begin
      case (paddr)
        `PSS_A_CTRL: begin
          d.seq_on = pwdata[`PSS_B_SEQ_ON];
          d.cfg_on = pwdata[`PSS_B_CFG_ON];
        end
        `PSS_A_FIRST: if (cfg_ok && set_ok(pwdata)) d.first = pwdata[4:0];
        `PSS_A_PICK:  if (set_ok(pwdata)) d.pick = pwdata[4:0]; // R3 R21
        `PSS_A_ROUTE: d.route = pwdata[0]; // R4
        `PSS_A_NEXT: begin
          if (cfg_ok && set_ok(pwdata)) begin // R22
            d.tbl[q.pick][q.route].succ = pwdata[4:0]; // R3
          end
        end
        `PSS_A_SRC: begin
          if (cfg_ok) begin // R22
            d.tbl[q.pick][q.route].src = pss_pkg::pss_src_e'(pwdata[2:0]); // R9
          end
        end
        `PSS_A_LIMIT: begin
          if (cfg_ok && pwdata[8:0] != 9'h0 && pwdata[31:0] <= 32'h100) begin
            d.limit = pwdata[8:0]; // R18
          end
        end
        `PSS_A_LOAD: begin
          if (~q.seq_on && pwdata[0]) begin // R3
            d.active = q.pick;
            d.load_p = 1'b1;
          end
        end
        default: d.limit = d.limit;
      endcase
    end

    // ==========================================
    // sequencer
    if (!q.seq_on) begin
      d.armed  = 1'b1;
      d.pend_v = 1'b0;
      d.cnt    = 9'h0;
    end else if (q.armed) begin
      if (frame_start) begin
        d.active = q.first; // R1
        d.load_p = 1'b1;
        d.armed  = 1'b0;
        d.cnt    = 9'h001;
      end
    end else begin
      if (frame_start) begin
        d.cnt = cnt_n; // R17
        if (f0) begin // R25
          d.active = p0.succ; // R7 R8
          d.load_p = 1'b1;
        end else if (f1) begin
          d.active = p1.succ; // R6 R8
          d.load_p = 1'b1;
        end else if (q.pend_v) begin
          d.active = q.pend_set; // R11
          d.load_p = 1'b1;
        end // R24
        d.pend_v = 1'b0;
        if (cnt_end) begin // R11 R12
          d.pend_v   = 1'b1;
          d.pend_set = p1.succ;
        end
      end
      // software pulses bypass the frame start; a pulse in the same
      // cycle as a frame start overrides it
      if (wr && paddr == `PSS_A_SWP) begin // R14
        for (int k = 0; k < 3; k++) begin
          if (pwdata[k] && p0.src == pss_pkg::pss_src_e'(3'h3 + k[2:0])) sw0 = 1'b1;
          if (pwdata[k] && p1.src == pss_pkg::pss_src_e'(3'h3 + k[2:0])) sw1 = 1'b1;
        end
        if (sw0) begin // R13 R25
          d.active = p0.succ;
          d.load_p = 1'b1;
          d.pend_v = 1'b0;
        end else if (sw1) begin // R13
          d.active = p1.succ;
          d.load_p = 1'b1;
          d.pend_v = 1'b0;
        end
      end
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= '0;
      q.limit  <= `PSS_RST_LIMIT;
      q.armed  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata      = q.prdata;
  assign pready      = q.pready;
  assign pslverr     = q.pslverr;
  assign active_set  = q.active;
  assign set_load    = q.load_p;
  assign seq_running = q.seq_on;

  // ==========================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic run;
  assign run = q.seq_on & ~q.armed;

  sequence s_arm_fs;
    q.seq_on && q.armed && frame_start;
  endsequence

  property p_first_load;
    s_arm_fs |=> set_load && active_set == $past(q.first) && !q.armed;
  endproperty
  a_first_load: assert property (p_first_load) else $error("first set not loaded"); // R1

  property p_line_path0;
    run && frame_start && f0 && !(wr && paddr == `PSS_A_SWP)
      |=> set_load && active_set == $past(p0.succ);
  endproperty
  a_line_path0: assert property (p_line_path0) else $error("path 0 not taken"); // R25

  property p_path1;
    run && frame_start && !f0 && f1 && !(wr && paddr == `PSS_A_SWP)
      |=> active_set == $past(p1.succ);
  endproperty
  a_path1: assert property (p_path1) else $error("path 1 not taken"); // R8

  property p_keep;
    run && frame_start && !f0 && !f1 && !q.pend_v && !(wr && paddr == `PSS_A_SWP)
      |=> $stable(active_set) && !set_load;
  endproperty
  a_keep: assert property (p_keep) else $error("set changed without request"); // R24

  sequence s_cnt_end;
    run && frame_start && cnt_end && !f0 && !f1 && !wr;
  endsequence

  property p_pend;
    s_cnt_end ##1 (!frame_start && !wr)[*2] |=> $stable(active_set) && q.pend_v;
  endproperty
  a_pend: assert property (p_pend) else $error("sync source loaded early"); // R11

  property p_cnt_range;
    run |-> q.cnt >= 9'h001 && q.cnt <= q.limit;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("counter out of range"); // R17

  property p_limit;
    q.limit != 9'h0 && q.limit <= `PSS_MAX_LIMIT;
  endproperty
  a_limit: assert property (p_limit) else $error("limit out of range"); // R18

  property p_locked;
    q.seq_on |=> $stable(q.tbl) || !$past(q.seq_on);
  endproperty
  a_locked: assert property (p_locked) else $error("table written in sequencer mode"); // R22

  property p_sw;
    run && wr && paddr == `PSS_A_SWP && (sw0 || sw1) |=> set_load;
  endproperty
  a_sw: assert property (p_sw) else $error("software pulse not loaded"); // R13

  property p_sw_wins;
    run && wr && paddr == `PSS_A_SWP && sw0 |=> active_set == $past(p0.succ);
  endproperty
  a_sw_wins: assert property (p_sw_wins) else $error("path 0 pulse lost"); // R25

  property p_sw_refused;
    run && wr && paddr == `PSS_A_SWP && !sw0 && !sw1 && !frame_start |=> !set_load;
  endproperty
  a_sw_refused: assert property (p_sw_refused) else $error("stray pulse loaded a set"); // R13

  property p_pend_load;
    run && frame_start && q.pend_v && !f0 && !f1 && !(wr && paddr == `PSS_A_SWP)
      |=> set_load && active_set == $past(q.pend_set);
  endproperty
  a_pend_load: assert property (p_pend_load) else $error("pending set not loaded"); // R11

  property p_cnt_wrap;
    run && frame_start && q.cnt >= q.limit |=> q.cnt == 9'h001;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter did not wrap"); // R17

  property p_cnt_step;
    run && frame_start && q.cnt < q.limit |=> q.cnt == $past(q.cnt) + 9'h001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter did not step"); // R17

  property p_load_cmd;
    !q.seq_on && wr && paddr == `PSS_A_LOAD && pwdata[0]
      |=> set_load && active_set == $past(q.pick);
  endproperty
  a_load_cmd: assert property (p_load_cmd) else $error("load command ignored"); // R3

  property p_ready;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not a single pulse");
endmodule : pss_sequencer

/* File: design/pss_defs.svh */
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
// ==========================================
// register byte offsets
`define PSS_A_CTRL   8'h00
`define PSS_A_FIRST  8'h04
`define PSS_A_PICK   8'h08
`define PSS_A_ROUTE  8'h0c
`define PSS_A_NEXT   8'h10
`define PSS_A_SRC    8'h14
`define PSS_A_LIMIT  8'h18
`define PSS_A_SWP    8'h1c
`define PSS_A_STAT   8'h20
`define PSS_A_LOAD   8'h24
// ==========================================
// field positions
`define PSS_B_SEQ_ON  0
`define PSS_B_CFG_ON  1
`define PSS_B_POL     8
`define PSS_B_ARMED   8
`define PSS_B_PEND    9
`define PSS_B_RUN     10
`define PSS_B_CNT     16
// ==========================================
// reset values and limits
`define PSS_RST_LIMIT 9'h001
`define PSS_RST_SRC   3'h0
`define PSS_MAX_LIMIT 9'h100
`endif

/* File: design/pss_pkg.sv */
package pss_pkg;
  // ==========================================
  // advance source encodings
  typedef enum logic [2:0] {
    SRC_LINE1  = 3'h0,
    SRC_LINE3  = 3'h1,
    SRC_LINE4  = 3'h2,
    SRC_SW1    = 3'h3,
    SRC_SW2    = 3'h4,
    SRC_SW3    = 3'h5,
    SRC_CNTEND = 3'h6,
    SRC_FSTART = 3'h7
  } pss_src_e;

  typedef struct packed {
    logic [4:0] succ;
    pss_src_e   src;
  } pss_path_s;

  typedef struct packed {
    logic                  seq_on;
    logic                  cfg_on;
    logic [4:0]            first;
    logic [4:0]            pick;
    logic                  route;
    logic [8:0]            limit;
    pss_path_s [31:0][1:0] tbl;
    logic [4:0]            active;
    logic                  armed;
    logic                  pend_v;
    logic [4:0]            pend_set;
    logic [8:0]            cnt;
    logic                  load_p;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } pss_state_s;
endpackage : pss_pkg

/* File: verif/pss_lines.sv */
`timescale 1ns/10ps
// ==========================================
// far side: frame start source and trigger lines
module pss_lines (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fs_req,
  input  wire logic [2:0] lvl_req,
  output logic            frame_start,
  output logic            line1_in,
  output logic            line3_in,
  output logic            line4_in
);
  // lines drop after the frame, so a stale level never reads as a request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {frame_start, line4_in, line3_in, line1_in} <= 4'h0;
    end else begin
      frame_start <= fs_req;
      {line4_in, line3_in, line1_in} <= fs_req ? lvl_req : 3'h0;
    end
  end
endmodule : pss_lines

/* File: verif/parameter_set_sequencer_test.sv */
`timescale 1ns/10ps
`include "pss_defs.svh"
module parameter_set_sequencer_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        frame_start, line1_in, line3_in, line4_in, set_load, seq_running, fs_req;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic [4:0]  active_set;
  logic [2:0]  lvl_req;
  logic [32:0] exp_rd[$];
  logic [4:0]  exp_set[$];
  int          n_fail, n_tests, seed, k;

  pss_sequencer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .frame_start, .line1_in, .line3_in, .line4_in, .active_set,
    .set_load, .seq_running);
  pss_lines u_far (.pclk, .presetn, .fs_req, .lvl_req, .frame_start, .line1_in, .line3_in,
    .line4_in);

  // ==========================================
  // tasks
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] want);
    n_tests++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk

  task automatic finish_test;
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic cfg(input int j, input int r, input logic [31:0] s, input logic [2:0] c);
    wr(`PSS_A_PICK, 32'(j));
    wr(`PSS_A_ROUTE, 32'(r));
    wr(`PSS_A_NEXT, s);
    wr(`PSS_A_SRC, {29'h0, c});
  endtask : cfg

  // lines are {line4, line3, line1}
  task automatic fs(input logic [2:0] l, input logic ld, input logic [4:0] e);
    if (ld) exp_set.push_back(e);
    @(posedge pclk);
    fs_req <= 1'b1;
    lvl_req <= l;
    @(posedge pclk);
    fs_req <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : fs

  // ==========================================
  // clock, watcher, watchdog
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // sampled at the rising edge, before that edge's update lands
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      chk("read", {pslverr, prdata}, exp_rd.pop_front());
    end
    if (set_load === 1'b1) begin
      chk("active_set", {28'h0, active_set},
          exp_set.size() > 0 ? {28'h0, exp_set.pop_front()} : 33'h1_ffff_ffff);
    end
  end

  initial begin
    #(100 * 20000);
    n_fail++;
    finish_test();
  end

  // ==========================================
  // main sequence
  initial begin
    seed = 10;
    {presetn, psel, penable, pwrite, fs_req} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    lvl_req = 3'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`PSS_A_STAT, 33'h100);
    rd(`PSS_A_LIMIT, 33'h1);
    rd(8'h40, 33'h1_0000_0000);
    wr(`PSS_A_CTRL, 32'h2);
    wr(`PSS_A_LIMIT, 32'h0);
    wr(`PSS_A_LIMIT, 32'h101);
    rd(`PSS_A_LIMIT, 33'h1);
    wr(`PSS_A_LIMIT, 32'h100);
    rd(`PSS_A_LIMIT, 33'h100);
    wr(`PSS_A_LIMIT, 32'h2);
    wr(`PSS_A_PICK, 32'h1f);
    wr(`PSS_A_PICK, 32'h20);
    rd(`PSS_A_PICK, 33'h1f);
    for (k = 0; k < 8; k++) begin
      v = $random(seed) & 32'h1f;
      cfg(5, k % 2, v, k[2:0]);
      rd(`PSS_A_NEXT, {1'b0, v});
      rd(`PSS_A_SRC, 33'h100 | 33'(k));
    end
    wr(`PSS_A_FIRST, 32'h0);
    cfg(0, 0, 0, pss_pkg::SRC_LINE3);
    cfg(0, 1, 1, pss_pkg::SRC_LINE4);
    cfg(1, 0, 0, pss_pkg::SRC_LINE3);
    cfg(1, 1, 2, pss_pkg::SRC_FSTART);
    cfg(2, 0, 0, pss_pkg::SRC_LINE3);
    cfg(2, 1, 3, pss_pkg::SRC_CNTEND);
    cfg(3, 0, 0, pss_pkg::SRC_SW2);
    cfg(3, 1, 0, pss_pkg::SRC_LINE1);
    wr(`PSS_A_PICK, 32'h2);
    exp_set.push_back(5'h2);
    wr(`PSS_A_LOAD, 32'h1);
    wr(`PSS_A_CTRL, 32'h1);
    wr(`PSS_A_NEXT, 32'h5);
    rd(`PSS_A_NEXT, 33'h3);
    chk("seq_running", {32'h0, seq_running}, 33'h1);
    fs(3'h0, 1'b1, 5'h0);
    fs(3'h0, 1'b0, 5'h0);
    fs(3'h4, 1'b1, 5'h1);
    fs(3'h2, 1'b1, 5'h0);
    fs(3'h4, 1'b1, 5'h1);
    fs(3'h0, 1'b1, 5'h2);
    fs(3'h0, 1'b0, 5'h0);
    fs(3'h0, 1'b0, 5'h0);
    fs(3'h0, 1'b1, 5'h3);
    rd(`PSS_A_STAT, 33'h0_0001_0403);
    wr(`PSS_A_SWP, 32'h1);
    exp_set.push_back(5'h0);
    wr(`PSS_A_SWP, 32'h2);
    repeat (5) @(posedge pclk);
    chk("queues", 33'(exp_set.size() + exp_rd.size()), 33'h0);
    finish_test();
  end
endmodule : parameter_set_sequencer_test
